// ==== rtl/spcr_params.svh ====
// Register map and timing constants for the serial config register port.
// Assumes inclusion by bare name from both ends and the bench.
`ifndef SPCR_PARAMS_SVH
`define SPCR_PARAMS_SVH
// Register addresses on the serial link
`define SPCR_ADDR_CFG 13'h0000
`define SPCR_ADDR_PID 13'h0003
`define SPCR_ADDR_RBK 13'h0004
`define SPCR_ADDR_UPD 13'h0232
// Field positions in the port configuration, readback select and update bytes
`define SPCR_BIT_LONG 3
`define SPCR_BIT_SRST 2
`define SPCR_BIT_LSBF 1
`define SPCR_BIT_OSEL 0
`define SPCR_BIT_RBK 0
`define SPCR_BIT_UPD 0
// Reset values
`define SPCR_CFG_RST 8'h18
`define SPCR_RBK_RST 8'h00
`define SPCR_UPD_RST 8'h00
// Config bits forced high on every write: long instruction and its mirror
`define SPCR_CFG_FORCE 8'h18
// Config bits kept through soft reset: reset bit and its mirror
`define SPCR_CFG_KEEP 8'h24
// Instruction frame: 16-bit instruction, read flag at the top bit
`define SPCR_INST_BITS 16
`define SPCR_BIT_RW 15
// Controller APB register offsets (byte addresses)
`define SPCR_APB_CMD 12'h000
`define SPCR_APB_WDATA 12'h004
`define SPCR_APB_STAT 12'h008
`define SPCR_APB_RDATA 12'h00c
`define SPCR_APB_MODE 12'h010
// Controller link clock half period in pclk cycles
`define SPCR_SCLK_HALF 4
`endif

// ==== rtl/spcr_pkg.sv ====
// Types shared by both ends of the serial config register port.
// Assumes spcr_params.svh is on the include path.
package spcr_pkg;
    // Device side shift states, Gray coded along the frame
    typedef enum logic [1:0] {
        SPCR_D_IDLE = 2'b00,
        SPCR_D_INST = 2'b01,
        SPCR_D_DATA = 2'b11
    } spcr_dev_st_t;
    // Controller states, Gray coded along the frame
    typedef enum logic [2:0] {
        SPCR_H_IDLE = 3'b000,
        SPCR_H_LO = 3'b001,
        SPCR_H_HI = 3'b011,
        SPCR_H_DONE = 3'b010
    } spcr_host_st_t;
endpackage

// ==== rtl/spcr_if.sv ====
// Serial link between controller and register device.
// Assumes the bench resolves the two-way data pin from the enables.
`timescale 1ns/1ns
interface spcr_if;
    logic sclk;                  // Link clock from controller
    logic cs_n;                  // Frame select, active low
    logic sdio_h_o;              // Controller drive of data pin
    logic sdio_h_oe;             // Controller enable on data pin
    logic sdio_d_o;              // Device drive of data pin
    logic sdio_d_oe;             // Device enable on data pin
    logic sdio_i;                // Resolved data pin level
    logic serial_output_pin;     // Device separate output
    logic serial_output_pin_oe;  // Device enable on separate output
    modport dev (input sclk, input cs_n, input sdio_i,
                 output sdio_d_o, output sdio_d_oe,
                 output serial_output_pin, output serial_output_pin_oe);
    modport host (output sclk, output cs_n, input sdio_i,
                  output sdio_h_o, output sdio_h_oe,
                  input serial_output_pin, input serial_output_pin_oe);
endinterface // spcr_if

// ==== rtl/spcr_sync.sv ====
// Two flip-flop synchroniser for link pins.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/1ns
module spcr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q; // First stage, read only by second
    // Two stages, constant reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // spcr_sync

// ==== rtl/spcr_dev.sv ====
// Register device end: port config, part_identification, readback select, update.
// Assumes the controller frames 16-bit instructions, data bytes follow.
//
// Design decision made here: register access over the serial link only.
`timescale 1ns/1ns
`include "spcr_params.svh"
module spcr_dev #(
    parameter logic [7:0] PART_IDENTIFICATION = 8'h5a // Arbitrary neutral value
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    spcr_if.dev link,
    // User side: active settings for internal blocks
    output logic [7:0] act_cfg,
    output logic act_rbk
);
    logic sclk_s, cs_n_s, sdi_s;  // Synchronised pins
    logic sclk_d1_q;              // Previous link clock level
    logic rise, fall;             // Link clock edges
    spcr_pkg::spcr_dev_st_t st_q;
    logic [3:0] cnt_q;            // Bit counter within field
    logic [15:0] sh_q;            // Input shift register
    logic rd_q;                   // Current frame is a read
    logic [12:0] addr_q;          // Current register address
    logic [7:0] tx_q;             // Output byte being shifted
    logic [7:0] cfg_q, rbk_q;     // Buffered registers
    logic [7:0] act_cfg_q;        // Active copy of config
    logic act_rbk_q;              // Active readback select
    logic upd_q;                  // Update request bit
    logic drv_q, sdo_q;           // Output drive and level
    logic [7:0] rx_byte;          // Completed byte, order applied
    logic [7:0] rd_byte;          // Read value for address
    logic lsbf;                   // Active bit order

    spcr_sync #(.W(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({link.sclk, link.cs_n, link.sdio_i}),
        .q({sclk_s, cs_n_s, sdi_s})
    );

    // Link clock edge finder on synchronised level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d1_q <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_s;
        end
    end
    assign rise = sclk_s & ~sclk_d1_q;
    assign fall = ~sclk_s & sclk_d1_q;
    // Bit order follows the active copy, so a config write or update changes it from the next byte
    assign lsbf = act_cfg_q[`SPCR_BIT_LSBF];

    // Assemble received byte; LSB-first bytes arrive reversed
    always_comb begin
        rx_byte = {sh_q[6:0], sdi_s};
        if (lsbf) begin
            rx_byte = {<<{rx_byte}};
        end
    end

    // Read mux, bank chosen by readback select
    always_comb begin
        rd_byte = 8'h00;
        case (addr_q)
            `SPCR_ADDR_CFG: rd_byte = act_rbk_q ? act_cfg_q : cfg_q;
            `SPCR_ADDR_PID: rd_byte = PART_IDENTIFICATION;
            `SPCR_ADDR_RBK: rd_byte = act_rbk_q ? {7'h00, act_rbk_q}
                                                : rbk_q;
            `SPCR_ADDR_UPD: rd_byte = {7'h00, upd_q};
            default: rd_byte = 8'h00;
        endcase
    end

    // Frame state, counters, address stepping on rising link edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= spcr_pkg::SPCR_D_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 16'h0000;
            rd_q <= 1'b0;
            addr_q <= 13'h0000;
        end else if (cs_n_s) begin
            st_q <= spcr_pkg::SPCR_D_IDLE;
            cnt_q <= 4'h0;
        end else if (rise) begin
            sh_q <= {sh_q[14:0], sdi_s};
            cnt_q <= cnt_q + 4'h1;
            case (st_q)
                spcr_pkg::SPCR_D_IDLE, spcr_pkg::SPCR_D_INST: begin
                    st_q <= spcr_pkg::SPCR_D_INST;
                    if (cnt_q == 4'hf) begin
                        st_q <= spcr_pkg::SPCR_D_DATA;
                        rd_q <= sh_q[`SPCR_BIT_RW-1];
                        addr_q <= {sh_q[11:0], sdi_s};
                        cnt_q <= 4'h0;
                    end
                end
                spcr_pkg::SPCR_D_DATA: begin
                    if (cnt_q == 4'h7) begin
                        cnt_q <= 4'h0;
                        addr_q <= lsbf ? addr_q + 13'h0001
                                       : addr_q - 13'h0001;
                    end
                end
                default: st_q <= spcr_pkg::SPCR_D_IDLE;
            endcase
        end
    end

    // Buffered writes, soft reset, update transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `SPCR_CFG_RST;
            rbk_q <= `SPCR_RBK_RST;
            upd_q <= 1'b0;
            act_cfg_q <= `SPCR_CFG_RST;
            act_rbk_q <= 1'b0;
        end else begin
            if (act_cfg_q[`SPCR_BIT_SRST]) begin
                rbk_q <= `SPCR_RBK_RST;
                upd_q <= 1'b0;
                act_rbk_q <= 1'b0;
                // Keep the reset bit itself so software can clear it
                act_cfg_q <= `SPCR_CFG_RST | (cfg_q & `SPCR_CFG_KEEP);
            end
            if (upd_q) begin
                act_cfg_q <= cfg_q;
                act_rbk_q <= rbk_q[`SPCR_BIT_RBK];
                upd_q <= 1'b0;
            end
            if (!cs_n_s && rise && st_q == spcr_pkg::SPCR_D_DATA
                && cnt_q == 4'h7 && !rd_q) begin
                case (addr_q)
                    `SPCR_ADDR_CFG: begin
                        // Long bit forced; config acts at once
                        cfg_q <= rx_byte | `SPCR_CFG_FORCE;
                        act_cfg_q <= rx_byte | `SPCR_CFG_FORCE;
                    end
                    `SPCR_ADDR_RBK: rbk_q <= rx_byte;
                    `SPCR_ADDR_UPD: upd_q <= rx_byte[`SPCR_BIT_UPD];
                    // Part_identification and unmapped addresses drop the byte
                    default: ;
                endcase
            end
        end
    end

    // Read shift out on falling link edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_q <= 8'h00;
            drv_q <= 1'b0;
            sdo_q <= 1'b0;
        end else if (cs_n_s) begin
            drv_q <= 1'b0;
        end else if (fall && rd_q && st_q == spcr_pkg::SPCR_D_DATA) begin
            drv_q <= 1'b1;
            if (cnt_q == 4'h0) begin
                tx_q <= rd_byte;
                sdo_q <= lsbf ? rd_byte[0] : rd_byte[7];
            end else begin
                sdo_q <= lsbf ? tx_q[cnt_q[2:0]]
                              : tx_q[3'h7 - cnt_q[2:0]];
            end
        end
    end

    // Pin steering by output select
    assign link.sdio_d_o = sdo_q;
    assign link.sdio_d_oe = drv_q & ~act_cfg_q[`SPCR_BIT_OSEL];
    assign link.serial_output_pin = sdo_q;
    assign link.serial_output_pin_oe = drv_q
                                     & act_cfg_q[`SPCR_BIT_OSEL];
    assign act_cfg = act_cfg_q;
    assign act_rbk = act_rbk_q;
endmodule // spcr_dev

// ==== rtl/spcr_host.sv ====
// Controller end: APB slave registers drive one-byte serial frames.
// Assumes the device samples on rising and shifts on falling link edges.
`timescale 1ns/1ns
`include "spcr_params.svh"
module spcr_host (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link
    spcr_if.host link
);
    spcr_pkg::spcr_host_st_t st_q;
    logic [15:0] inst_q;      // Instruction word (read flag, address)
    logic [7:0] wdat_q;       // Byte to write
    logic [7:0] rdat_q;       // Byte read back
    logic [1:0] mode_q;       // [0] LSB first, [1] separate output pin
    logic busy_q;             // Frame running
    logic [4:0] bit_q;        // Bit index over 24 bits
    logic [2:0] div_q;        // Half period divider
    logic sclk_q, cs_n_q, do_q, oe_q;
    logic [31:0] prdata_q;
    logic sdi_s, sdo_s;       // Synchronised return pins
    logic acc, start, tick, last;
    logic [23:0] frame;
    logic [7:0] wdat_rev;     // Write byte in reversed bit order

    spcr_sync #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({link.sdio_i, link.serial_output_pin}),
        .q({sdi_s, sdo_s})
    );

    // Zero-wait slave: every access completes in its first access cycle
    assign acc = psel & penable;
    assign start = acc & pwrite & (paddr == `SPCR_APB_CMD) & ~busy_q;
    assign tick = (div_q == 3'(`SPCR_SCLK_HALF - 1));
    assign last = (bit_q == 5'd23);
    // Bit reversal of the write byte, one wire per bit
    for (genvar i = 0; i < 8; i++) begin : g_rev
        assign wdat_rev[i] = wdat_q[7-i];
    end
    // Data byte reversed for LSB-first order; instruction always MSB first
    assign frame = {inst_q, mode_q[0] ? wdat_rev : wdat_q};

    // APB register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inst_q <= 16'h0000;
            wdat_q <= 8'h00;
            mode_q <= 2'b00;
        end else if (acc && pwrite) begin
            case (paddr)
                `SPCR_APB_CMD: if (!busy_q) inst_q <= pwdata[15:0];
                `SPCR_APB_WDATA: wdat_q <= pwdata[7:0];
                `SPCR_APB_MODE: mode_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // APB read data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `SPCR_APB_CMD: prdata_q <= {16'h0000, inst_q};
                `SPCR_APB_WDATA: prdata_q <= {24'h000000, wdat_q};
                `SPCR_APB_STAT: prdata_q <= {31'h0, busy_q};
                `SPCR_APB_RDATA: prdata_q <= {24'h000000, rdat_q};
                `SPCR_APB_MODE: prdata_q <= {30'h0, mode_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Frame sequencer: 16 instruction bits then one data byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= spcr_pkg::SPCR_H_IDLE;
            busy_q <= 1'b0;
            bit_q <= 5'd0;
            div_q <= 3'd0;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            do_q <= 1'b0;
            oe_q <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            div_q <= tick ? 3'd0 : div_q + 3'd1;
            case (st_q)
                spcr_pkg::SPCR_H_IDLE: begin
                    div_q <= 3'd0;
                    if (start) begin
                        busy_q <= 1'b1;
                        cs_n_q <= 1'b0;
                        bit_q <= 5'd0;
                        st_q <= spcr_pkg::SPCR_H_LO;
                    end
                end
                spcr_pkg::SPCR_H_LO: begin
                    // Drive bit while clock low; release pin for read data
                    do_q <= frame[5'd23 - bit_q];
                    oe_q <= ~(inst_q[`SPCR_BIT_RW] && bit_q > 5'd15);
                    if (tick) begin
                        sclk_q <= 1'b1;
                        st_q <= spcr_pkg::SPCR_H_HI;
                    end
                end
                spcr_pkg::SPCR_H_HI: begin
                    if (tick) begin
                        sclk_q <= 1'b0;
                        if (bit_q > 5'd15) begin
                            rdat_q <= mode_q[0]
                                ? {mode_q[1] ? sdo_s : sdi_s, rdat_q[7:1]}
                                : {rdat_q[6:0], mode_q[1] ? sdo_s : sdi_s};
                        end
                        bit_q <= bit_q + 5'd1;
                        st_q <= last ? spcr_pkg::SPCR_H_DONE
                                     : spcr_pkg::SPCR_H_LO;
                    end
                end
                spcr_pkg::SPCR_H_DONE: begin
                    if (tick) begin
                        cs_n_q <= 1'b1;
                        oe_q <= 1'b0;
                        busy_q <= 1'b0;
                        st_q <= spcr_pkg::SPCR_H_IDLE;
                    end
                end
                default: st_q <= spcr_pkg::SPCR_H_IDLE;
            endcase
        end
    end
    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.sdio_h_o = do_q;
    assign link.sdio_h_oe = oe_q;
endmodule // spcr_host

// ==== verif/spcr_asserts.sv ====
// Checker for the serial link between controller and register device.
// Assumes plain inputs taken from spcr_if, clocked by pclk.
`timescale 1ns/1ns
module spcr_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_h_o,
    input wire logic sdio_h_oe,
    input wire logic sdio_d_oe,
    input wire logic serial_output_pin_oe
);
    logic sclk_q; // Link clock one cycle back
    logic [5:0] rise_q; // Link clock rises seen in this frame

    // Delay line for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
        end
    end

    // Count rises per frame; cleared while deselected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_q <= 6'h0;
        end else if (cs_n) begin
            rise_q <= 6'h0;
        end else if (sclk && !sclk_q) begin
            rise_q <= rise_q + 6'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_no_clash;
        !(sdio_h_oe && sdio_d_oe);
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive the data pin");
    property p_one_out;
        !(sdio_d_oe && serial_output_pin_oe);
    endproperty
    a_one_out: assert property (p_one_out)
        else $error("device drives both output pins");
    property p_quiet;
        cs_n [*8] |-> !sdio_d_oe && !serial_output_pin_oe;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("device drives while deselected");
    property p_dev_frame;
        $rose(sdio_d_oe) |-> !cs_n;
    endproperty
    a_dev_frame: assert property (p_dev_frame)
        else $error("device starts driving outside a frame");
    property p_sclk_idle;
        cs_n |-> !sclk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("link clock not idle low");
    property p_sclk_high;
        $rose(sclk) |-> sclk [*4] ##1 !sclk;
    endproperty
    a_sclk_high: assert property (p_sclk_high)
        else $error("link clock high phase wrong");
    property p_sclk_low;
        $fell(sclk) && !cs_n |-> !sclk [*4];
    endproperty
    a_sclk_low: assert property (p_sclk_low)
        else $error("link clock low phase too short");
    property p_frame_len;
        $fell(cs_n) |-> !cs_n [*8] ##[1:600] cs_n;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame length out of range");
    property p_bit_count;
        $rose(cs_n) |-> rise_q == 6'd24;
    endproperty
    a_bit_count: assert property (p_bit_count)
        else $error("frame does not hold 24 link clocks");
    property p_host_hold;
        sclk && $past(sclk) && sdio_h_oe && $past(sdio_h_oe)
            |-> $stable(sdio_h_o);
    endproperty
    a_host_hold: assert property (p_host_hold)
        else $error("host data moves while link clock high");
endmodule // spcr_asserts

// ==== verif/tb.sv ====
// Bench: APB host end and device end joined over spcr_if.
// Assumes spcr_params.svh on the include path; bench resolves the pin.
`timescale 1ns/1ns
`include "spcr_params.svh"
module tb;
    localparam logic [7:0] PID = 8'h4d; // Arbitrary variant code
    logic pclk = 1'b0; // Bus clock
    logic presetn = 1'b0; // Reset, active low
    logic psel = 1'b0; // APB request lines
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata; // APB answer
    logic pready;
    logic pslverr;
    logic [7:0] act_cfg; // Device active settings
    logic act_rbk;
    logic uni = 1'b0; // Host reads on separate pin
    logic lsb = 1'b0; // Host in LSB first mode
    logic sclk_q = 1'b0; // Monitor state
    logic cs_q = 1'b1;
    logic [15:0] bit_n = 16'h0;
    logic [15:0] sop_n = 16'h0;
    logic [23:0] wire_q = 24'h0;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    spcr_if bus();
    // Pull-up when nobody drives, so a released pin never looks held
    assign bus.sdio_i = bus.sdio_h_oe ? bus.sdio_h_o :
                        bus.sdio_d_oe ? bus.sdio_d_o : 1'b1;

    spcr_host spcr_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(bus));
    spcr_dev #(.PART_IDENTIFICATION(PID)) spcr_dev_inst (.pclk(pclk),
        .presetn(presetn), .link(bus), .act_cfg(act_cfg),
        .act_rbk(act_rbk));
    spcr_asserts spcr_asserts_inst (.pclk(pclk), .presetn(presetn),
        .sclk(bus.sclk), .cs_n(bus.cs_n), .sdio_h_o(bus.sdio_h_o),
        .sdio_h_oe(bus.sdio_h_oe), .sdio_d_oe(bus.sdio_d_oe),
        .serial_output_pin_oe(bus.serial_output_pin_oe));

    // Clock, 50 ns period
    always #25 pclk = ~pclk;

    // Wire monitor: one bit per link clock rise, from the live pin
    always @(posedge pclk) begin
        sclk_q <= bus.sclk;
        cs_q <= bus.cs_n;
        if (bus.serial_output_pin_oe === 1'b1) begin
            sop_n <= sop_n + 16'h1;
        end
        if (cs_q && !bus.cs_n) begin
            bit_n <= 16'h0;
        end else if (!bus.cs_n && bus.sclk && !sclk_q) begin
            bit_n <= bit_n + 16'h1;
            wire_q <= {wire_q[22:0], bus.serial_output_pin_oe ?
                       bus.serial_output_pin : bus.sdio_i};
        end
    end

    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            summarize();
        end
    end

    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = b[7-i];
        end
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; request held until a rising edge sees pready,
    // read data taken at that same edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic setmode(input logic u, input logic l);
        logic [31:0] r;
        uni = u;
        lsb = l;
        apb(1'b1, `SPCR_APB_MODE, {30'h0, u, l}, r);
    endtask

    // One-byte frame; v is written or expected, the wire is judged too
    task automatic xfer(input logic rd, input logic [12:0] a,
                        input logic [7:0] v, output logic [7:0] q);
        logic [31:0] r;
        logic [15:0] s0;
        s0 = sop_n;
        apb(1'b1, `SPCR_APB_WDATA, {24'h0, v}, r);
        apb(1'b1, `SPCR_APB_CMD, {16'h0, rd, 2'b00, a}, r);
        r = 32'h1;
        for (int n = 0; n < 200 && r[0] !== 1'b0; n++) begin
            apb(1'b0, `SPCR_APB_STAT, 32'h0, r);
        end
        apb(1'b0, `SPCR_APB_RDATA, 32'h0, r);
        q = r[7:0];
        chk(bit_n, 16'd24, "bit count");
        chk(wire_q[23:8], {rd, 2'b00, a}, "instruction");
        chk(16'(wire_q[7:0]), 16'(lsb ? rev8(v) : v), "wire byte");
        chk({15'h0, sop_n != s0}, {15'h0, rd & uni}, "out pin");
    endtask

    task automatic t_reset();
        logic [7:0] q;
        logic [31:0] r;
        chk(16'(act_cfg), 16'h18, "act_cfg");
        chk(16'(act_rbk), 16'h0, "act_rbk");
        xfer(1'b1, `SPCR_ADDR_CFG, 8'h18, q);
        chk(16'(q), 16'h18, "cfg read");
        apb(1'b0, `SPCR_APB_CMD, 32'h0, r);
        chk(r[15:0], 16'h8000, "cmd readback");
        apb(1'b0, `SPCR_APB_WDATA, 32'h0, r);
        chk(r[15:0], 16'h0018, "wdata readback");
        apb(1'b0, 12'h100, 32'h0, r);
        chk(r[15:0], 16'h0, "unmapped");
    endtask

    task automatic t_pid();
        logic [7:0] q;
        xfer(1'b0, `SPCR_ADDR_PID, 8'h00, q);
        xfer(1'b1, `SPCR_ADDR_PID, PID, q);
        chk(16'(q), 16'(PID), "part_identification");
    endtask

    task automatic t_uni();
        logic [7:0] q;
        xfer(1'b0, `SPCR_ADDR_CFG, 8'h99, q);
        chk(16'(act_cfg), 16'h99, "act_cfg uni");
        setmode(1'b1, 1'b0);
        xfer(1'b1, `SPCR_ADDR_PID, PID, q);
        chk(16'(q), 16'(PID), "uni read");
        xfer(1'b0, `SPCR_ADDR_CFG, 8'h18, q);
        setmode(1'b0, 1'b0);
        xfer(1'b1, `SPCR_ADDR_PID, PID, q);
        chk(16'(q), 16'(PID), "two-way read");
    endtask

    // 0x5a and 0x18 read the same in either bit order
    task automatic t_lsb();
        logic [7:0] q;
        xfer(1'b0, `SPCR_ADDR_CFG, 8'h5a, q);
        chk(16'(act_cfg), 16'h5a, "act_cfg lsb");
        setmode(1'b0, 1'b1);
        xfer(1'b1, `SPCR_ADDR_PID, PID, q);
        chk(16'(q), 16'(PID), "lsb read");
        xfer(1'b0, `SPCR_ADDR_RBK, 8'h06, q);
        xfer(1'b1, `SPCR_ADDR_RBK, 8'h06, q);
        chk(16'(q), 16'h06, "lsb write");
        xfer(1'b0, `SPCR_ADDR_CFG, 8'h18, q);
        setmode(1'b0, 1'b0);
    endtask

    task automatic t_bank();
        logic [7:0] q;
        xfer(1'b0, `SPCR_ADDR_RBK, 8'h01, q);
        xfer(1'b1, `SPCR_ADDR_RBK, 8'h01, q);
        chk(16'(act_rbk), 16'h0, "rbk before update");
        xfer(1'b0, `SPCR_ADDR_UPD, 8'h01, q);
        chk(16'(act_rbk), 16'h1, "rbk after update");
        xfer(1'b1, `SPCR_ADDR_UPD, 8'h00, q);
        chk(16'(q), 16'h0, "update cleared");
        xfer(1'b0, `SPCR_ADDR_RBK, 8'h00, q);
        xfer(1'b1, `SPCR_ADDR_RBK, 8'h01, q);
        chk(16'(q), 16'h1, "active bank read");
    endtask

    task automatic t_srst();
        logic [7:0] q;
        xfer(1'b0, `SPCR_ADDR_CFG, 8'h3c, q);
        chk(16'(act_rbk), 16'h0, "rbk in reset");
        xfer(1'b0, `SPCR_ADDR_CFG, 8'h18, q);
        chk(16'(act_cfg), 16'h18, "cfg after reset");
        xfer(1'b1, `SPCR_ADDR_RBK, 8'h00, q);
        chk(16'(q), 16'h0, "rbk after reset");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pid();
        t_uni();
        t_lsb();
        t_bank();
        t_srst();
        summarize();
    end
endmodule // tb
